// ---- design/ssc_pkg.sv ----
package ssc_pkg;
  // widths
  localparam int DUR_W = 16;
  localparam int SER_W = 32;
  localparam int CNT_W = 4;
  localparam int GEN_W = 8;
  // sleep option bit positions
  localparam int OPT_W = 8;
  localparam int OPT_PREF_BIT = 0;
  localparam int OPT_NONCOORD_BIT = 1;
  localparam int OPT_NO_DEPLOY_BIT = 2;
  localparam int OPT_NOMINATE_BIT = 3;
  localparam int OPT_NO_EARLY_BIT = 4;
  localparam int OPT_SUPPORT_LOW_BIT = 5;
  localparam int OPT_BUTTON_BIT = 6;
  // miss thresholds
  localparam logic [CNT_W-1:0] MISS_REQ_LIM = 4'h6;
  localparam logic [CNT_W-1:0] MISS_NOM_LIM = 4'h3;
  localparam logic [CNT_W-1:0] MISS_SAT = 4'hF;
  // timing: one duration unit, deployment resend spacing, relay listen window
  localparam int CLK_HZ = 20_000_000;
  localparam int UNIT_US = 1000;
  localparam int UNIT_CYC = UNIT_US * (CLK_HZ / 1_000_000);
  localparam int DEPLOY_GAP_UNITS = 4;
  localparam int RELAY_WAIT_UNITS = 2;
  localparam int UNIT_CW = 15;
  localparam logic [UNIT_CW-1:0] UNIT_LAST = UNIT_CW'(UNIT_CYC - 1);
  localparam logic [DUR_W-1:0] DEPLOY_GAP = DUR_W'(DEPLOY_GAP_UNITS);
  localparam logic [DUR_W-1:0] RELAY_WAIT = DUR_W'(RELAY_WAIT_UNITS);
  localparam logic [DUR_W-1:0] GUARD_SHIFT_BASE = 16'h0040;

  typedef enum logic [1:0] {MSG_SYNC, MSG_REQ, MSG_RELAY} ssc_kind_e;

  // a sync or request message as seen on the radio link
  typedef struct packed {
    ssc_kind_e kind;
    logic [GEN_W-1:0] gen;
    logic deploy;
    logic pref;
    logic support;
    logic [SER_W-1:0] serial;
    logic [DUR_W-1:0] wake;
    logic [DUR_W-1:0] sleep;
  } ssc_msg_s;

  typedef enum {ST_SLEEP, ST_WAKE} ssc_phase_e;
endpackage

// ---- design/ssc_seen_mem.sv ----
`timescale 1ns/1ps
// remembers which sync generations were already received; registered read
module ssc_seen_mem
  import ssc_pkg::*;
(
  input wire logic ref_clk_i, // clock
  input wire logic rst_n_i, // async reset
  input wire logic [GEN_W-1:0] addr_i, // generation
  input wire logic we_i, // mark received
  output logic seen_o // registered hit
);
  logic [(1<<GEN_W)-1:0] mem_reg;

  // flag array and read register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_reg <= '0;
      seen_o <= 1'b0;
    end else begin
      if (we_i) begin
        mem_reg[addr_i] <= 1'b1;
      end
      seen_o <= mem_reg[addr_i];
    end
  end
endmodule // ssc_seen_mem

// ---- design/ssc_core.sv ----
`timescale 1ns/1ps
module ssc_core
  import ssc_pkg::*;
(
  input wire logic ref_clk_i, // 20 MHz clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [OPT_W-1:0] sleep_options_i, // option bits
  input wire logic [DUR_W-1:0] sleep_period_setting_i, // host sleep period
  input wire logic [DUR_W-1:0] wake_time_setting_i, // host wake time
  input wire logic net_param_change_i, // hop/delay/discovery/retry changed pulse
  input wire logic support_node_i, // support node flag for seniority and syncs; does not keep awake_o high
  input wire logic routing_node_i, // node relays
  input wire logic [SER_W-1:0] serial_i, // own serial number
  input wire logic button_double_i, // double press pulse
  input wire logic button_nominate_command_i, // nominate command pulse
  input wire logic rx_valid_i, // received message pulse
  input wire ssc_msg_s rx_msg_i, // received message
  output logic tx_valid_o, // send message pulse
  output ssc_msg_s tx_msg_o, // message to send
  output logic awake_o, // radio awake
  output logic tx_window_o, // usable transmit window
  output logic coordinator_o, // acting coordinator
  output logic synced_o, // has been synchronised
  output logic deploy_o, // deployment mode
  output logic [DUR_W-1:0] operating_sleep_query_o, // operating sleep
  output logic [DUR_W-1:0] operating_wake_query_o // operating wake
);
  typedef struct packed {
    ssc_phase_e phase;
    logic [UNIT_CW-1:0] pre;
    logic [DUR_W-1:0] cnt;
    logic [DUR_W-1:0] op_wake;
    logic [DUR_W-1:0] op_sleep;
    logic [DUR_W-1:0] set_wake;
    logic [DUR_W-1:0] set_sleep;
    logic [GEN_W-1:0] gen;
    logic coord;
    logic synced;
    logic deploy;
    logic got_sync;
    logic relay_heard;
    logic resent;
    logic [DUR_W-1:0] listen;
    logic [DUR_W-1:0] dgap;
    logic [CNT_W-1:0] miss;
    logic pend_change;
    logic tx_v;
    ssc_msg_s tx;
    logic win;
  } ssc_state_s;

  ssc_state_s s_reg, s_next;
  logic seen;
  logic opt_nc;

  // senior check: newer parameters, preferred, support, then serial
  function automatic logic is_senior(input ssc_msg_s m, input logic [GEN_W-1:0] g, input logic pref,
                                     input logic sup, input logic sup_low, input logic [SER_W-1:0] ser);
    logic a_sup;
    logic b_sup;
    a_sup = sup_low ? ~m.support : m.support;
    b_sup = sup_low ? ~sup : sup;
    if (m.gen != g) return (m.gen - g) < GEN_W'(1 << (GEN_W - 1));
    if (m.pref != pref) return m.pref;
    if (a_sup != b_sup) return a_sup;
    return m.serial > ser;
  endfunction

  // guard grows with missed syncs and cycle length
  function automatic logic [DUR_W-1:0] guard_len(input logic [DUR_W-1:0] slp, input logic [CNT_W-1:0] m);
    logic [DUR_W-1:0] g;
    g = (slp / GUARD_SHIFT_BASE) + DUR_W'(1);
    return DUR_W'(g * (DUR_W'(m) + DUR_W'(1)));
  endfunction

  assign opt_nc = sleep_options_i[OPT_NONCOORD_BIT];

  ssc_seen_mem u_seen (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(rx_msg_i.gen),
    .we_i(rx_valid_i && (rx_msg_i.kind == MSG_SYNC || rx_msg_i.kind == MSG_RELAY) && routing_node_i),
    .seen_o(seen)
  );

  // one-cycle delayed copy of every received message so the seen lookup lines up
  ssc_msg_s rx_d_reg;
  logic rx_d_v_reg;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_d_reg <= '0;
      rx_d_v_reg <= 1'b0;
    end else begin
      rx_d_reg <= rx_msg_i;
      rx_d_v_reg <= rx_valid_i;
    end
  end

  // next-state logic
  always_comb begin
    logic tick;
    logic wake_start;
    logic [DUR_W-1:0] gd;
    logic [DUR_W-1:0] early;
    tick = 1'b0;
    wake_start = 1'b0;
    gd = '0;
    early = '0;
    s_next = s_reg;
    s_next.tx_v = 1'b0;
    s_next.pre = s_reg.pre + UNIT_CW'(1);
    if (s_reg.pre == UNIT_LAST) begin
      s_next.pre = '0;
      tick = 1'b1;
    end
    // settings changes are noted and, unless non-coordinator, applied at the next wake start
    if (sleep_period_setting_i != s_reg.set_sleep || wake_time_setting_i != s_reg.set_wake) begin
      s_next.set_sleep = sleep_period_setting_i;
      s_next.set_wake = wake_time_setting_i;
      if (!opt_nc) s_next.pend_change = 1'b1;
    end
    if (net_param_change_i && !opt_nc) s_next.pend_change = 1'b1;
    if (sleep_options_i[OPT_PREF_BIT]) s_next.coord = 1'b1;
    if ((button_double_i || button_nominate_command_i) && sleep_options_i[OPT_BUTTON_BIT] && !opt_nc) begin
      s_next.coord = 1'b1;
    end
    if (opt_nc) s_next.coord = 1'b0;
    if (sleep_options_i[OPT_NO_DEPLOY_BIT]) s_next.deploy = 1'b0;
    // phase timer
    if (tick) begin
      if (s_reg.cnt != '0) begin
        s_next.cnt = s_reg.cnt - DUR_W'(1);
      end else if (s_reg.phase == ST_WAKE) begin
        s_next.phase = ST_SLEEP;
        early = sleep_options_i[OPT_NO_EARLY_BIT] ? '0 : DUR_W'(s_reg.op_sleep >> (CNT_W'(4) - s_reg.miss[3:2]));
        s_next.cnt = (s_reg.miss != '0) ? s_reg.op_sleep - early : s_reg.op_sleep;
      end else begin
        s_next.phase = ST_WAKE;
        s_next.cnt = s_reg.op_wake;
        wake_start = 1'b1;
      end
      if (s_reg.listen != '0) s_next.listen = s_reg.listen - DUR_W'(1);
      if (s_reg.dgap != '0) s_next.dgap = s_reg.dgap - DUR_W'(1);
    end
    if (wake_start) begin
      if (!s_reg.got_sync && !s_reg.coord && s_reg.miss != MISS_SAT) s_next.miss = s_reg.miss + CNT_W'(1);
      s_next.got_sync = 1'b0;
      if (s_reg.pend_change) begin
        s_next.coord = 1'b1;
        s_next.gen = s_reg.gen + GEN_W'(1);
        s_next.op_sleep = s_reg.set_sleep;
        s_next.op_wake = s_reg.set_wake;
        s_next.cnt = s_reg.set_wake;
        s_next.pend_change = 1'b0;
      end
      if (sleep_options_i[OPT_NOMINATE_BIT] && !opt_nc && s_reg.miss >= MISS_NOM_LIM) s_next.coord = 1'b1;
      if (s_next.coord) begin
        s_next.tx_v = 1'b1;
        s_next.relay_heard = 1'b0;
        s_next.resent = 1'b0;
        s_next.listen = RELAY_WAIT;
        s_next.dgap = DEPLOY_GAP;
        s_next.miss = '0;
      end else if (!s_reg.synced || (opt_nc && s_reg.miss >= MISS_REQ_LIM)) begin
        s_next.tx_v = 1'b1;
        s_next.tx.kind = MSG_REQ;
      end
    end else if (s_reg.coord && s_reg.phase == ST_WAKE && !s_reg.relay_heard) begin
      if (s_reg.deploy && s_reg.dgap == '0) begin
        s_next.tx_v = 1'b1;
        s_next.dgap = DEPLOY_GAP;
      end else if (!s_reg.deploy && !s_reg.resent && s_reg.listen == DUR_W'(1) && tick) begin
        s_next.tx_v = 1'b1;
        s_next.resent = 1'b1;
      end
    end
    // own sync contents
    if (s_next.tx_v && s_next.coord) begin
      s_next.tx.kind = MSG_SYNC;
      s_next.tx.gen = s_next.gen;
      s_next.tx.deploy = s_reg.deploy;
      s_next.tx.pref = sleep_options_i[OPT_PREF_BIT];
      s_next.tx.support = support_node_i;
      s_next.tx.serial = serial_i;
      s_next.tx.wake = s_next.op_wake;
      s_next.tx.sleep = s_next.op_sleep;
    end
    // received messages (one cycle late, aligned with the seen lookup)
    if (rx_d_v_reg) begin
      if (rx_d_reg.kind == MSG_REQ && s_reg.synced) begin
        s_next.tx_v = 1'b1;
        s_next.tx = s_reg.tx;
        s_next.tx.kind = MSG_SYNC;
        s_next.tx.gen = s_reg.gen;
        s_next.tx.deploy = s_reg.deploy;
        s_next.tx.wake = s_reg.op_wake;
        s_next.tx.sleep = s_reg.op_sleep;
        s_next.tx.serial = serial_i;
      end else if (rx_d_reg.kind == MSG_SYNC || rx_d_reg.kind == MSG_RELAY) begin
        if (s_reg.coord && rx_d_reg.serial != serial_i && rx_d_reg.gen == s_reg.gen && !seen) begin
          s_next.relay_heard = 1'b1; // neighbour relayed our sync
          s_next.deploy = 1'b0;
        end
        if (rx_d_reg.deploy && !s_reg.deploy && s_reg.synced) begin
          s_next.tx_v = 1'b1;
          s_next.tx.kind = MSG_SYNC;
          s_next.tx.gen = s_reg.gen;
          s_next.tx.deploy = 1'b0;
          s_next.tx.serial = serial_i;
          s_next.tx.wake = s_reg.op_wake;
          s_next.tx.sleep = s_reg.op_sleep;
        end else if (!s_reg.coord || is_senior(rx_d_reg, s_reg.gen, sleep_options_i[OPT_PREF_BIT],
                     support_node_i, sleep_options_i[OPT_SUPPORT_LOW_BIT], serial_i)) begin
          if (!sleep_options_i[OPT_PREF_BIT]) s_next.coord = 1'b0;
          s_next.op_wake = rx_d_reg.wake;
          s_next.op_sleep = rx_d_reg.sleep;
          s_next.gen = rx_d_reg.gen;
          s_next.synced = 1'b1;
          s_next.got_sync = 1'b1;
          s_next.miss = '0;
          // a settled network sync ends our own deployment phase
          if (!rx_d_reg.deploy) s_next.deploy = 1'b0;
          if (!seen) begin
            s_next.phase = ST_WAKE;
            s_next.cnt = rx_d_reg.wake;
            s_next.pre = '0;
          end
          if (routing_node_i && !seen) begin
            s_next.tx_v = 1'b1;
            s_next.tx = rx_d_reg;
            s_next.tx.kind = MSG_RELAY;
          end
        end
      end
    end
    // guard at both ends of the wake time
    gd = guard_len(s_reg.op_sleep, s_reg.miss);
    s_next.win = (s_next.phase == ST_WAKE) && (s_next.cnt > gd) && (s_next.op_wake - s_next.cnt > gd);
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '{phase: ST_WAKE, deploy: 1'b1, tx: '{kind: MSG_SYNC, default: '0}, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  always_comb begin
    tx_valid_o = s_reg.tx_v;
    tx_msg_o = s_reg.tx;
    awake_o = s_reg.phase == ST_WAKE;
    tx_window_o = s_reg.win;
    coordinator_o = s_reg.coord;
    synced_o = s_reg.synced;
    deploy_o = s_reg.deploy;
    operating_sleep_query_o = s_reg.op_sleep;
    operating_wake_query_o = s_reg.op_wake;
  end
endmodule // ssc_core

// ---- bench/ssc_core_sva.sv ----
`timescale 1ns/1ps
// port checks on the core
module ssc_core_sva
  import ssc_pkg::*;
(
  input wire logic ref_clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic [OPT_W-1:0] sleep_options_i, // options
  input wire logic routing_node_i, // relays
  input wire logic rx_valid_i, // rx pulse
  input wire ssc_msg_s rx_msg_i, // rx message
  input wire logic tx_valid_o, // tx pulse
  input wire ssc_msg_s tx_msg_o, // tx message
  input wire logic awake_o, // awake
  input wire logic tx_window_o, // window
  input wire logic coordinator_o, // coordinator
  input wire logic synced_o, // synced
  input wire logic deploy_o, // deploy
  input wire logic [DUR_W-1:0] operating_sleep_query_o, // op sleep
  input wire logic [DUR_W-1:0] operating_wake_query_o // op wake
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [(1<<GEN_W)-1:0] seen_reg;
  // relayed generations; a second relay would circulate forever
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) seen_reg <= '0;
    else if (tx_valid_o && tx_msg_o.kind == MSG_RELAY) seen_reg[tx_msg_o.gen] <= 1'b1;
  end
  sequence s_sync_in; rx_valid_i && rx_msg_i.kind == MSG_SYNC; endsequence
  sequence s_tx_sync; tx_valid_o && tx_msg_o.kind == MSG_SYNC; endsequence
  property p_reply; rx_valid_i && rx_msg_i.kind == MSG_REQ && synced_o |-> ##2 s_tx_sync; endproperty
  property p_adopt; s_sync_in ##0 (!rx_msg_i.deploy && !synced_o) |-> ##2 (synced_o &&
    operating_wake_query_o == $past(rx_msg_i.wake, 2) && operating_sleep_query_o == $past(rx_msg_i.sleep, 2));
  endproperty
  property p_relay; s_sync_in ##0 (!rx_msg_i.deploy && routing_node_i && !coordinator_o && !seen_reg[rx_msg_i.gen])
    |-> ##2 (tx_valid_o && tx_msg_o.kind == MSG_RELAY && tx_msg_o.gen == $past(rx_msg_i.gen, 2)); endproperty
  property p_once; tx_valid_o && tx_msg_o.kind == MSG_RELAY |-> !seen_reg[tx_msg_o.gen]; endproperty
  property p_correct; s_sync_in ##0 (rx_msg_i.deploy && !deploy_o && synced_o) |-> ##2 (s_tx_sync ##0 !tx_msg_o.deploy);
  endproperty
  property p_reject; s_sync_in ##0 (rx_msg_i.deploy && !deploy_o) |=> $stable(operating_wake_query_o) [*3]; endproperty
  property p_window; tx_window_o |-> awake_o; endproperty
  property p_guard; $rose(awake_o) |-> !tx_window_o [*8]; endproperty
  property p_pref; $rose(awake_o) && sleep_options_i[OPT_PREF_BIT] |-> ##[0:3] s_tx_sync; endproperty
  property p_no_dep; s_tx_sync ##0 (coordinator_o && sleep_options_i[OPT_NO_DEPLOY_BIT]) |-> !tx_msg_o.deploy;
  endproperty
  a_reply: assert property (p_reply) else $error("request not answered");
  a_adopt: assert property (p_adopt) else $error("sync timing not adopted");
  a_relay: assert property (p_relay) else $error("sync not relayed");
  a_once: assert property (p_once) else $error("generation relayed twice");
  a_correct: assert property (p_correct) else $error("no corrective sync");
  a_reject: assert property (p_reject) else $error("deployment sync adopted");
  a_window: assert property (p_window) else $error("window while asleep");
  a_guard: assert property (p_guard) else $error("no guard at wake start");
  a_pref: assert property (p_pref) else $error("no sync at wake start");
  a_no_dep: assert property (p_no_dep) else $error("deploy flag with deploy off");
endmodule // ssc_core_sva
bind ssc_core ssc_core_sva u_sva (.ref_clk_i, .rst_n_i, .sleep_options_i, .routing_node_i, .rx_valid_i, .rx_msg_i,
  .tx_valid_o, .tx_msg_o, .awake_o, .tx_window_o, .coordinator_o, .synced_o, .deploy_o, .operating_sleep_query_o,
  .operating_wake_query_o);

// ---- bench/ssc_peer.sv ----
`timescale 1ns/1ps
// far-side node: injects messages, logs what the core sends
module ssc_peer
  import ssc_pkg::*;
(
  input wire logic ref_clk_i, // clock
  input wire logic tx_valid_i, // core send pulse
  input wire ssc_msg_s tx_msg_i, // core message
  output logic rx_valid_o, // to core
  output ssc_msg_s rx_msg_o, // to core
  output int tx_cnt_o, // sends seen
  output ssc_msg_s tx_last_o // last send
);
  initial begin
    rx_valid_o = 1'b0;
    rx_msg_o = '0;
    tx_cnt_o = 0;
    tx_last_o = '0;
  end
  // one-cycle frame; afterwards junk, so a stale message never looks valid
  task automatic send(input ssc_msg_s m);
    @(negedge ref_clk_i);
    rx_valid_o = 1'b1;
    rx_msg_o = m;
    @(negedge ref_clk_i);
    rx_valid_o = 1'b0;
    rx_msg_o = ssc_msg_s'(~m);
  endtask
  // log every pulse from the core
  always @(posedge ref_clk_i) begin
    if (tx_valid_i === 1'b1) begin
      tx_cnt_o <= tx_cnt_o + 1;
      tx_last_o <= tx_msg_i;
    end
  end
endmodule // ssc_peer

// ---- bench/tb_sync_sleep_coordinator.sv ----
`timescale 1ns/1ps
// self-checking bench for the core
module tb_sync_sleep_coordinator
  import ssc_pkg::*;
;
  logic ref_clk_i;
  logic rst_n_i;
  logic [OPT_W-1:0] opt;
  logic [DUR_W-1:0] sp_set;
  logic [DUR_W-1:0] wk_set;
  logic btn2;
  logic btn_cmd;
  logic rx_valid;
  ssc_msg_s rx_msg;
  logic tx_valid;
  ssc_msg_s tx_msg;
  logic coord;
  logic synced;
  logic [DUR_W-1:0] op_sleep;
  logic [DUR_W-1:0] op_wake;
  int tx_cnt;
  ssc_msg_s tx_last;
  ssc_msg_s m;
  int n0;
  int bad_count;
  int comparisons;
  // support, serial and network-change inputs tied: outside this bench
  ssc_core dut (.ref_clk_i, .rst_n_i, .sleep_options_i(opt), .sleep_period_setting_i(sp_set),
    .wake_time_setting_i(wk_set), .net_param_change_i(1'b0), .support_node_i(1'b0), .routing_node_i(1'b1),
    .serial_i(32'h0000_00A5), .button_double_i(btn2), .button_nominate_command_i(btn_cmd), .rx_valid_i(rx_valid),
    .rx_msg_i(rx_msg), .tx_valid_o(tx_valid), .tx_msg_o(tx_msg), .awake_o(), .tx_window_o(), .coordinator_o(coord),
    .synced_o(synced), .deploy_o(), .operating_sleep_query_o(op_sleep), .operating_wake_query_o(op_wake));
  ssc_peer peer (.ref_clk_i, .tx_valid_i(tx_valid), .tx_msg_i(tx_msg), .rx_valid_o(rx_valid), .rx_msg_o(rx_msg),
    .tx_cnt_o(tx_cnt), .tx_last_o(tx_last));
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  function automatic ssc_msg_s mk(ssc_kind_e k, logic [7:0] g, logic d, logic [15:0] w, logic [15:0] s);
    return '{k, g, d, 1'b0, 1'b0, 32'h0000_0011, w, s};
  endfunction
  task automatic chk(input string name, input logic [DUR_W-1:0] exp, input logic [DUR_W-1:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // bounded wait for the next send; a hang ends the run
  task automatic wait_tx(input int lim);
    for (int i = 0; i < lim && tx_cnt == n0; i++) begin
      @(negedge ref_clk_i);
    end
    if (tx_cnt == n0) begin
      bad_count++;
      $display("MISMATCH send expected pulse seen none");
      end_sim();
    end
    n0 = tx_cnt;
  endtask
  task automatic do_reset(input logic [OPT_W-1:0] o, input logic [DUR_W-1:0] w, input logic [DUR_W-1:0] s);
    @(negedge ref_clk_i);
    rst_n_i = 1'b0;
    opt = o;
    wk_set = w;
    sp_set = s;
    repeat (10) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (20) @(negedge ref_clk_i);
    n0 = tx_cnt;
  endtask
  initial begin
    rst_n_i = 1'b0;
    opt = '0;
    sp_set = 16'h0001;
    wk_set = 16'h0001;
    btn2 = 1'b0;
    btn_cmd = 1'b0;
    bad_count = 0;
    comparisons = 0;
    n0 = 0;
    do_reset(8'h00, 16'h0001, 16'h0001);
    // fresh sync: adopted and relayed
    peer.send(mk(MSG_SYNC, 8'h05, 1'b0, 16'h0003, 16'h0007));
    wait_tx(6);
    chk("relay kind", 16'(MSG_RELAY), 16'(tx_last.kind));
    chk("relay gen", 16'h0005, 16'(tx_last.gen));
    chk("op wake", 16'h0003, op_wake);
    chk("op sleep", 16'h0007, op_sleep);
    chk("synced", 16'h0001, 16'(synced));
    peer.send(mk(MSG_SYNC, 8'h05, 1'b0, 16'h0003, 16'h0007));
    repeat (6) @(negedge ref_clk_i);
    chk("no second relay", 16'(n0), 16'(tx_cnt));
    $display("test adopt_relay done");
    // a joining node asks; the synced core answers with network timing
    peer.send(mk(MSG_REQ, 8'h00, 1'b0, 16'h0000, 16'h0000));
    wait_tx(6);
    chk("reply kind", 16'(MSG_SYNC), 16'(tx_last.kind));
    chk("reply wake", 16'h0003, tx_last.wake);
    $display("test request done");
    // deployment sync from a reset coordinator: refused, corrected
    peer.send(mk(MSG_SYNC, 8'h06, 1'b1, 16'h0009, 16'h0009));
    wait_tx(6);
    chk("corrective kind", 16'(MSG_SYNC), 16'(tx_last.kind));
    chk("corrective deploy", 16'h0000, 16'(tx_last.deploy));
    chk("kept wake", 16'h0003, op_wake);
    $display("test deploy_reject done");
    // button nomination: ignored as non-coordinator, taken otherwise
    opt = OPT_W'((1 << OPT_NONCOORD_BIT) | (1 << OPT_BUTTON_BIT));
    btn2 = 1'b1;
    @(negedge ref_clk_i);
    btn2 = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk("button ignored", 16'h0000, 16'(coord));
    opt = OPT_W'(1 << OPT_BUTTON_BIT);
    btn_cmd = 1'b1;
    @(negedge ref_clk_i);
    btn_cmd = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk("command nominates", 16'h0001, 16'(coord));
    $display("test button done");
    // preferred coordinator, deployment off; no relay, so exactly one resend
    do_reset(OPT_W'((1 << OPT_PREF_BIT) | (1 << OPT_NO_DEPLOY_BIT)), 16'h0002, 16'h0001);
    wait_tx(62000);
    chk("sync kind", 16'(MSG_SYNC), 16'(tx_last.kind));
    chk("sync deploy", 16'h0000, 16'(tx_last.deploy));
    chk("sync wake", 16'h0002, tx_last.wake);
    chk("sync sleep", 16'h0001, tx_last.sleep);
    chk("coordinator", 16'h0001, 16'(coord));
    m = tx_last;
    wait_tx(42000);
    chk("resend kind", 16'(MSG_SYNC), 16'(tx_last.kind));
    chk("resend gen", 16'(m.gen), 16'(tx_last.gen));
    $display("test coordinator done");
    end_sim();
  end
endmodule // tb_sync_sleep_coordinator
